//--- src/sleep_wake_defs.vh
`ifndef SLEEP_WAKE_DEFS_VH
`define SLEEP_WAKE_DEFS_VH
`define SEL_PENDING 4'h9
`define SEL_EDGE 4'hA
`define SEL_ENABLE 4'hB
`define SEL_DIRECTION 4'hF
`define WAKE_RESET_VALUE 8'hFF
`define DIR_RESET_VALUE 8'hFF
`define RESET_VECTOR 11'h7FF
`define SYNC_FILL_CYCLES 3'h5
`endif

//--- src/pin_edge_detect.v
`include "sleep_wake_defs.vh"
module pin_edge_detect #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire [WIDTH-1:0] pin_i,
  input wire [WIDTH-1:0] falling_sel_i,
  output wire [WIDTH-1:0] edge_o
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  reg [WIDTH-1:0] level;
  reg [2:0] fill;
  wire primed;
  genvar g;
  // Edges ignored until the chain holds real pin values, so an idle-high pin gives no false edge
  assign primed = (fill == `SYNC_FILL_CYCLES);
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1 <= {WIDTH{1'b0}};
      s2 <= {WIDTH{1'b0}};
      s3 <= {WIDTH{1'b0}};
      fill <= 3'h0;
    end else begin
      if (!primed) begin
        fill <= fill + 3'h1;
      end
      // Sync stages run even when frozen so the chain never holds stale metastability
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bit_g
      // Level accepted only when stages two and three agree
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          level[g] <= 1'b0;
        end else if (ce_i && (s2[g] == s3[g])) begin
          level[g] <= s3[g];
        end
      end
      assign edge_o[g] = ce_i && primed && (s2[g] == s3[g]) && (s3[g] != level[g]) &&
                         (falling_sel_i[g] ? !s3[g] : s3[g]);
    end
  endgenerate
endmodule

//--- src/sleep_wakeup_edge_control.v
`include "sleep_wake_defs.vh"
module sleep_wakeup_edge_control #(
  parameter WIDTH = 8,
  parameter WDT_BITS = 16
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire master_reset_pin_i,
  input wire sleep_exec_i,
  input wire watchdog_enable_i,
  input wire [3:0] port_select_i,
  input wire port_ctrl_write_i,
  input wire [WIDTH-1:0] working_reg_i,
  input wire [WIDTH-1:0] second_port_data_i,
  output reg [WIDTH-1:0] working_reg_o,
  output reg working_reg_load_o,
  output reg [WIDTH-1:0] wake_pin_enable_mask_o,
  output reg [WIDTH-1:0] wake_edge_polarity_o,
  output reg [WIDTH-1:0] wake_pending_flags_o,
  output reg [WIDTH-1:0] port_direction_o,
  output reg power_down_o,
  output wire core_run_o,
  output reg timeout_flag_o,
  output reg power_down_flag_o,
  output reg [10:0] pc_load_value_o,
  output reg pc_load_o,
  output wire ext_irq_o,
  output reg [WDT_BITS-1:0] watchdog_timer_o
);
  localparam ST_RUN = 1'b0;
  localparam ST_DOWN = 1'b1;

  wire [WIDTH-1:0] edges;
  wire [WIDTH-1:0] armed;
  wire mr_assert;
  wire wdt_overflow;
  wire pin_wake;
  wire wake_cause;
  wire port_write;
  wire sel_pending;
  wire sel_edge;
  wire sel_enable;
  wire sel_direction;
  wire wr_pending;

  reg mr1;
  reg mr2;
  reg mr3;
  reg state;

  // Next values, settled combinationally each cycle
  reg next_state;
  reg [WDT_BITS-1:0] next_watchdog;
  reg next_timeout;
  reg next_power_down_flag;
  reg next_pc_load;
  reg [WIDTH-1:0] next_pending;

  // Sync chain and settle filter add about four cycles of wake latency
  pin_edge_detect #(.WIDTH(WIDTH)) edge_u (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .pin_i(second_port_data_i),
    .falling_sel_i(wake_edge_polarity_o),
    .edge_o(edges)
  );

  // Pin side of the master reset, active low, filtered like the port pins
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      mr1 <= 1'b1;
      mr2 <= 1'b1;
      mr3 <= 1'b1;
    end else begin
      mr1 <= master_reset_pin_i;
      mr2 <= mr1;
      mr3 <= mr2;
    end
  end
  // Acts while stages two and three agree low
  assign mr_assert = (mr2 == mr3) && !mr3;

  // Selector decode; a halted core cannot reach any port register
  assign port_write = core_run_o && port_ctrl_write_i;
  assign sel_pending = (port_select_i == `SEL_PENDING);
  assign sel_edge = (port_select_i == `SEL_EDGE);
  assign sel_enable = (port_select_i == `SEL_ENABLE);
  assign sel_direction = (port_select_i == `SEL_DIRECTION);
  assign wr_pending = port_write && sel_pending;

  // Same pending and enable logic feeds wakeup and interrupt
  assign armed = wake_pending_flags_o & ~wake_pin_enable_mask_o;
  assign pin_wake = |armed;
  assign ext_irq_o = pin_wake && !power_down_o;
  assign wdt_overflow = watchdog_enable_i && (&watchdog_timer_o);
  assign wake_cause = wdt_overflow || pin_wake;
  assign core_run_o = ce_i && !power_down_o;

  // Register file behind the port selector
  always @(posedge clk_i) begin
    if (sys_rst_i || mr_assert) begin
      wake_pin_enable_mask_o <= `WAKE_RESET_VALUE;
      wake_edge_polarity_o <= `WAKE_RESET_VALUE;
      port_direction_o <= `DIR_RESET_VALUE;
      working_reg_o <= {WIDTH{1'b0}};
      working_reg_load_o <= 1'b0;
    end else if (ce_i) begin
      working_reg_load_o <= 1'b0;
      if (port_write && sel_edge) begin
        wake_edge_polarity_o <= working_reg_i;
      end
      if (port_write && sel_enable) begin
        wake_pin_enable_mask_o <= working_reg_i;
      end
      if (port_write && sel_direction) begin
        port_direction_o <= working_reg_i;
      end
      // Only the pending register exchanges; the rest copy
      if (wr_pending) begin
        working_reg_o <= wake_pending_flags_o;
        working_reg_load_o <= 1'b1;
      end
    end
  end

  // Edge set wins over an exchange clear in the same cycle
  always @* begin
    next_pending = wake_pending_flags_o | edges;
    if (wr_pending) begin
      next_pending = working_reg_i | edges;
    end
  end

  // No reset: firmware must clear the flags before enabling
  always @(posedge clk_i) begin
    if (ce_i) begin
      wake_pending_flags_o <= next_pending;
    end
  end

  // Power-down sequencing; the watchdog counts in both states
  always @* begin
    next_state = state;
    next_watchdog = watchdog_timer_o;
    next_timeout = timeout_flag_o;
    next_power_down_flag = power_down_flag_o;
    next_pc_load = 1'b0;
    if (watchdog_enable_i) begin
      next_watchdog = watchdog_timer_o + {{(WDT_BITS-1){1'b0}}, 1'b1};
    end
    case (state)
      ST_RUN: begin
        if (sleep_exec_i) begin
          next_state = ST_DOWN;
          if (watchdog_enable_i) begin
            next_watchdog = {WDT_BITS{1'b0}};
            next_timeout = 1'b1;
            next_power_down_flag = 1'b0;
          end
        end else if (wdt_overflow) begin
          // Overflow while running restarts the core too
          next_timeout = 1'b0;
          next_pc_load = 1'b1;
        end
      end
      ST_DOWN: begin
        // Sleep pulses while down are ignored
        if (wake_cause) begin
          next_state = ST_RUN;
          next_pc_load = 1'b1;
          if (wdt_overflow) begin
            next_timeout = 1'b0;
          end
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // Status flags and restart vector
  always @(posedge clk_i) begin
    if (sys_rst_i || mr_assert) begin
      state <= ST_RUN;
      power_down_o <= 1'b0;
      watchdog_timer_o <= {WDT_BITS{1'b0}};
      timeout_flag_o <= 1'b1;
      power_down_flag_o <= 1'b1;
      pc_load_value_o <= `RESET_VECTOR;
      pc_load_o <= mr_assert;
    end else if (ce_i) begin
      state <= next_state;
      power_down_o <= (next_state == ST_DOWN);
      watchdog_timer_o <= next_watchdog;
      timeout_flag_o <= next_timeout;
      power_down_flag_o <= next_power_down_flag;
      pc_load_value_o <= `RESET_VECTOR;
      pc_load_o <= next_pc_load;
    end
  end
endmodule

//--- sim/sleep_wake_monitor.sv
module sleep_wake_monitor (
  input wire clk_i,
  input wire sys_rst_i,
  input wire sleep_exec_i,
  input wire watchdog_enable_i,
  input wire port_ctrl_write_i,
  input wire [3:0] port_select_i,
  input wire core_run_o,
  input wire [7:0] working_reg_o,
  input wire working_reg_load_o,
  input wire [7:0] wake_pin_enable_mask_o,
  input wire [7:0] wake_pending_flags_o,
  input wire power_down_o,
  input wire timeout_flag_o,
  input wire power_down_flag_o,
  input wire pc_load_o,
  input wire [10:0] pc_load_value_o,
  input wire ext_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pending is unknown until the first exchange
  reg known = 1'b0;
  wire xchg = port_ctrl_write_i && core_run_o && port_select_i == 4'h9;
  wire [7:0] act = wake_pending_flags_o & ~wake_pin_enable_mask_o;
  always @(posedge clk_i) if (xchg) known <= 1'b1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sleep_entry_a: assert property (sleep_exec_i && core_run_o |=> power_down_o) else $error("no sleep");
  core_halt_a: assert property (power_down_o |-> !core_run_o) else $error("core runs");
  wdt_flags_a: assert property (sleep_exec_i && core_run_o && watchdog_enable_i
    |=> timeout_flag_o && !power_down_flag_o) else $error("flags");
  pin_wake_a: assert property (power_down_o && |act |=> !power_down_o && pc_load_o) else $error("no wake");
  wake_vector_a: assert property (pc_load_o |-> pc_load_value_o == 11'h7FF) else $error("vector");
  irq_share_a: assert property (ext_irq_o == (core_run_o && |act)) else $error("irq");
  pend_swap_a: assert property (known && xchg
    |=> working_reg_load_o && working_reg_o == $past(wake_pending_flags_o)) else $error("swap");
  pend_hold_a: assert property (known && !$past(port_ctrl_write_i)
    |-> ($past(wake_pending_flags_o) & ~wake_pending_flags_o) == 8'h00) else $error("lost");
endmodule
bind sleep_wakeup_edge_control sleep_wake_monitor u_mon (.*);

//--- sim/wake_pins.sv
module wake_pins (
  input wire clk_i,
  output logic [7:0] pins_o = 8'h00,
  output logic mrst_n_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  task put(input logic [7:0] v);
    @(posedge clk_i) pins_o <= v;
  endtask
  // Held low past the input synchroniser
  task reset_pulse;
    @(posedge clk_i) mrst_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    mrst_n_o <= 1'b1;
  endtask
endmodule

//--- sim/sleep_wakeup_edge_control_test.sv
module sleep_wakeup_edge_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, sys_rst_i = 1, sleep_exec_i = 0, watchdog_enable_i = 0, port_ctrl_write_i = 0;
  logic [3:0] port_select_i = 4'h0;
  logic [7:0] working_reg_i = 8'h00, ed_m, en_m;
  wire [7:0] pins, dir, working_reg_o, wake_pin_enable_mask_o, wake_edge_polarity_o, wake_pending_flags_o;
  wire [10:0] pc_load_value_o;
  wire working_reg_load_o, power_down_o, timeout_flag_o, power_down_flag_o, pc_load_o, ext_irq_o, mrst_n, core_run;
  wire [3:0] wdt;
  int failures = 0, cmp_count = 0, mp;
  wake_pins u_pins (.clk_i(clk_i), .pins_o(pins), .mrst_n_o(mrst_n));
  sleep_wakeup_edge_control #(.WDT_BITS(4)) u_dut (.*, .ce_i(1'b1), .master_reset_pin_i(mrst_n),
    .second_port_data_i(pins), .port_direction_o(dir), .core_run_o(core_run), .watchdog_timer_o(wdt));
  always #5 clk_i = ~clk_i;
  task complete_run;
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
    $display("%s test done", m);
  endtask
  task wr(input logic [3:0] s, input logic [7:0] v);
    @(posedge clk_i) begin
      port_select_i <= s;
      working_reg_i <= v;
      port_ctrl_write_i <= 1'b1;
    end
    @(posedge clk_i) port_ctrl_write_i <= 1'b0;
    #1;
  endtask
  task cfg(input logic [7:0] e, input logic [7:0] n);
    ed_m = e;
    en_m = n;
    wr(4'hA, e);
    wr(4'h9, 8'h00);
    mp = 0;
    wr(4'hB, n);
  endtask
  task edge_to(input logic [7:0] v);
    mp = mp | ((~pins & v & ~ed_m) | (pins & ~v & ed_m));
    u_pins.put(v);
    repeat (6) @(posedge clk_i);
    #1 chk(wake_pending_flags_o === mp[7:0] && ext_irq_o === |(mp[7:0] & ~en_m), "edge");
  endtask
  task nap(input logic w);
    @(posedge clk_i) begin
      sleep_exec_i <= 1'b1;
      watchdog_enable_i <= w;
    end
    @(posedge clk_i) sleep_exec_i <= 1'b0;
    #1 chk(power_down_o === 1'b1 && core_run === 1'b0, "sleep");
    chk(!w || timeout_flag_o === 1'b1 && power_down_flag_o === 1'b0 && wdt === 4'h0, "flags");
  endtask
  task wake;
    repeat (40) begin
      @(posedge clk_i);
      #1;
      if (pc_load_o === 1'b1) break;
    end
    chk(pc_load_o === 1'b1 && pc_load_value_o === 11'h7FF, "wake");
    if (pc_load_o !== 1'b1) complete_run;
  endtask
  initial begin
    void'($urandom(32'h34be735d));
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1 chk(wake_pin_enable_mask_o === 8'hFF && wake_edge_polarity_o === 8'hFF && dir === 8'hFF, "reset");
    cfg(8'($urandom), 8'($urandom));
    wr(4'hF, 8'h0F);
    wr(4'h5, 8'h00);
    chk(wake_edge_polarity_o === ed_m && wake_pin_enable_mask_o === en_m && dir === 8'h0F && working_reg_load_o === 1'b0, "select");
    repeat (4) edge_to(8'($urandom));
    wr(4'h9, 8'h00);
    chk(working_reg_load_o === 1'b1 && working_reg_o === mp[7:0] && wake_pending_flags_o === 8'h00, "swap");
    mp = 0;
    edge_to(8'hFF);
    cfg(8'hFF, 8'h00);
    nap(1'b0);
    u_pins.put(8'hFE);
    wake();
    cfg(8'hFF, 8'hFF);
    nap(1'b1);
    wake();
    wr(4'hA, 8'h00);
    nap(1'b0);
    fork
      u_pins.reset_pulse();
    join_none
    wake();
    chk(wake_edge_polarity_o === 8'hFF && wake_pin_enable_mask_o === 8'hFF, "pin reset");
    complete_run;
  end
endmodule
